// ==== design/sacs_defines.vh ====
// Constants of the converter control sequencer
// Notes on behaviour
// - Resolution bit picks 8-bit or 10-bit.
// - Results go per input, or all to zero.
// - Reference connect bit cuts or keeps reference.
// - Three select bits choose conversion clock divider.
// - Channel field picks input, single-input modes only.
// - Two-bit field selects one of four modes.
// - Sweep-one bit overrides into repeat sweep one.
// - Start bit, or pin falling edge, starts conversion.
// - Hardware triggers restart a running conversion.
// - Source bit picks pin or timer request.
// - Control writes mid conversion spoil that result.
// - Conversion cycle counts 49/59 or 28/33.
// - Group select routes one of four groups.
// - Extended field picks normal, extra, or amplifier.
// - Sweep set field sizes the swept input set.
// - Status field shows group being swept.
// - One-shot completion raises interrupt request.
// - Software-triggered one-shot or sweep clears start.
`ifndef SACS_DEFINES_VH
`define SACS_DEFINES_VH
// Register byte addresses
`define SACS_ADDR_CTRL_C 12'h394
`define SACS_ADDR_CTRL_D 12'h395
`define SACS_ADDR_CTRL_A 12'h396
`define SACS_ADDR_CTRL_B 12'h397
`define SACS_ADDR_CTRL_E 12'h398
`define SACS_ADDR_RES_BASE 12'h380
// Reset values
`define SACS_RST_CTRL 8'h00
// Control A fields
`define SACS_A_CHAN_LSB 0
`define SACS_A_MODE_LSB 3
`define SACS_A_TRG 5
`define SACS_A_START 6
`define SACS_A_DIV_A 7
// Control B fields
`define SACS_B_SWEEP_LSB 0
`define SACS_B_SWEEP1 2
`define SACS_B_RES10 3
`define SACS_B_DIV_B 4
`define SACS_B_REF 5
`define SACS_B_EXT_LSB 6
// Control C fields
`define SACS_C_SMP 0
`define SACS_C_GROUP_LSB 1
`define SACS_C_TRG_SRC 5
// Control D fields
`define SACS_D_DMA 0
`define SACS_D_MPS 1
`define SACS_D_DIV_C 2
`define SACS_D_STAT_LSB 3
// Operating mode codes
`define SACS_MODE_ONESHOT 2'h0
`define SACS_MODE_REPEAT 2'h1
`define SACS_MODE_SWEEP 2'h2
`define SACS_MODE_RSWEEP 2'h3
// Conversion lengths in conversion clock cycles
`define SACS_CYC_PLAIN_8 6'h31
`define SACS_CYC_PLAIN_10 6'h3b
`define SACS_CYC_SH_8 6'h1c
`define SACS_CYC_SH_10 6'h21
`define SACS_SAMP_PLAIN 6'h02
`define SACS_SAMP_SH 6'h03
`endif

// ==== design/sacs_adc_ctrl.v ====
// Converter control sequencer: registers, divider, triggers, results
`timescale 1ns/10ps
`include "sacs_defines.vh"
module sacs_adc_ctrl (
  input wire mclk,
  input wire sys_rst,
  input wire [11:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire ext_trigger_pin,
  input wire timer_irq,
  input wire [9:0] ana_data,
  output reg [1:0] ana_group,
  output reg [2:0] ana_chan,
  output reg [1:0] ana_ext,
  output reg ana_sample,
  output reg ana_convert,
  output reg ana_res10,
  output reg ref_connect,
  output reg adc_irq
);
  // Sequencer states; waiting only exists for hardware triggers
  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_CONV = 2'h2;

  // Control registers as software sees them
  reg [7:0] ctrl_a;
  reg [7:0] ctrl_b;
  reg [7:0] ctrl_c;
  reg [7:0] ctrl_d;
  reg [1:0] ctrl_e;

  // Sequencer, divider and sweep position
  reg [1:0] state;
  reg [2:0] div_cnt;
  reg [5:0] conv_cnt;
  reg [2:0] idx;
  reg [1:0] cur_group;
  reg second_group;

  // Trigger pin synchroniser and its edge stage
  reg ext_s1;
  reg ext_s2;
  reg ext_s3;
  // Result store, one entry per input of a group
  reg [9:0] res [0:7];

  // Decoded fields
  // Plain slices, so a register write counts from the next edge on
  wire [2:0] chan_sel = ctrl_a[`SACS_A_CHAN_LSB+2:`SACS_A_CHAN_LSB];
  wire [1:0] mode_fld = ctrl_a[`SACS_A_MODE_LSB+1:`SACS_A_MODE_LSB];
  wire trg_sel = ctrl_a[`SACS_A_TRG];
  wire start_bit = ctrl_a[`SACS_A_START];

  // Control B, C and D fields
  wire [1:0] sweep_set = ctrl_b[`SACS_B_SWEEP_LSB+1:`SACS_B_SWEEP_LSB];
  wire sweep1 = ctrl_b[`SACS_B_SWEEP1];
  wire res10 = ctrl_b[`SACS_B_RES10];
  wire sample_hold_enable = ctrl_c[`SACS_C_SMP];
  wire [1:0] grp_sel = ctrl_c[`SACS_C_GROUP_LSB+1:`SACS_C_GROUP_LSB];
  wire trg_src = ctrl_c[`SACS_C_TRG_SRC];
  wire dma_mode = ctrl_d[`SACS_D_DMA];
  wire mps_en = ctrl_d[`SACS_D_MPS];

  // Sweep-one bit forces repeat sweep regardless of the mode field
  // The field itself keeps its written value, so reads show it as set
  wire [1:0] mode = sweep1 ? `SACS_MODE_RSWEEP : mode_fld;
  wire single_in = (mode == `SACS_MODE_ONESHOT) ||
                   (mode == `SACS_MODE_REPEAT);
  wire stop_after = (mode == `SACS_MODE_ONESHOT) ||
                    (mode == `SACS_MODE_SWEEP);

  // Divider ratio minus one from the three select bits
  // Codes with c and a both set are not defined; they fall back to /8
  // so the conversion clock never runs faster than asked
  reg [2:0] div_max;
  always @*
  begin
    case ({ctrl_d[`SACS_D_DIV_C], ctrl_a[`SACS_A_DIV_A],
           ctrl_b[`SACS_B_DIV_B]})
      3'h0: div_max = 3'h3;
      3'h1: div_max = 3'h2;
      3'h2: div_max = 3'h1;
      3'h3: div_max = 3'h0;
      3'h4: div_max = 3'h7;
      3'h5: div_max = 3'h5;
      default: div_max = 3'h7;
    endcase
  end

  // Conversion length and sampling window in conversion clocks
  // Counts include the sampling window, which opens each conversion
  reg [5:0] conv_len;
  reg [5:0] samp_len;
  always @*
  begin
    if (sample_hold_enable)
    begin
      conv_len = res10 ? `SACS_CYC_SH_10 : `SACS_CYC_SH_8;
      samp_len = `SACS_SAMP_SH;
    end
    else
    begin
      conv_len = res10 ? `SACS_CYC_PLAIN_10 : `SACS_CYC_PLAIN_8;
      samp_len = `SACS_SAMP_PLAIN;
    end
  end

  // Last input index of a sweep
  // Multi-port sweep always takes all eight inputs of each group;
  // sweep one runs 0..s, the other sweeps run 0..2s+1
  reg [2:0] last_idx;
  always @*
  begin
    if (mps_en)
      last_idx = 3'h7;
    else if (sweep1)
      last_idx = {1'b0, sweep_set};
    else
      last_idx = {sweep_set, 1'b1};
  end

  // Input being converted; channel field only counts in single-input modes
  wire [2:0] cur_in = single_in ? chan_sel : idx;
  // One conversion clock per divider wrap
  wire phi_tick = (div_cnt == div_max);
  // Last conversion clock of the running conversion
  wire conv_end = (state == ST_CONV) && phi_tick &&
                  (conv_cnt == conv_len - 6'h01);
  // Falling edge of the synchronised pin
  wire ext_fall = ext_s3 & ~ext_s2;

  // Pin edge or timer request, chosen by the source bit
  wire hw_event = trg_src ? timer_irq : ext_fall;
  // A trigger only counts while the start bit stays set
  wire retrig = trg_sel && start_bit && hw_event &&
                (state != ST_IDLE);
  // Control A write strobe and end of the swept set
  wire wr_a = reg_wr && (reg_addr == `SACS_ADDR_CTRL_A);
  wire sweep_last = (idx == last_idx);
  // Self-clear: software trigger, single-shot modes, whole job done;
  // hardware-triggered jobs keep the bit and go back to waiting
  wire hw_clear = conv_end && stop_after && !trg_sel &&
                  (single_in || (sweep_last && !(mps_en && !second_group)));

  // Pin synchroniser plus one stage for edge detection
  // Reset to the idle high level so no false fall follows reset;
  // only the second stage and the edge stage are read by logic
  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ext_s1 <= 1'b1;
      ext_s2 <= 1'b1;
      ext_s3 <= 1'b1;
    end
    else
    begin
      ext_s1 <= ext_trigger_pin;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
    end
  end

  // Control registers; writes mid conversion are taken as they come
  // The result is undefined then, but blocking the write would hide
  // a setting from software until the converter happens to stop
  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctrl_a <= `SACS_RST_CTRL;
      ctrl_b <= `SACS_RST_CTRL;
      ctrl_c <= `SACS_RST_CTRL;
      ctrl_d <= `SACS_RST_CTRL;
      ctrl_e <= 2'h0;
    end
    else
    begin
      // A software write wins over the self-clear of the start bit
      if (wr_a)
        ctrl_a <= reg_wdata;
      else if (hw_clear)
        ctrl_a[`SACS_A_START] <= 1'b0;
      if (reg_wr && reg_addr == `SACS_ADDR_CTRL_B)
        ctrl_b <= reg_wdata;
      // Control C bits 4:3 do not exist and read as zero
      if (reg_wr && reg_addr == `SACS_ADDR_CTRL_C)
        ctrl_c <= {reg_wdata[7:5], 2'h0, reg_wdata[2:0]};
      // Status bits of control D are kept out of the write
      if (reg_wr && reg_addr == `SACS_ADDR_CTRL_D)
      begin
        ctrl_d[2:0] <= reg_wdata[2:0];
        ctrl_d[7:5] <= reg_wdata[7:5];
      end
      if (reg_wr && reg_addr == `SACS_ADDR_CTRL_E)
        ctrl_e <= reg_wdata[1:0];
      // Status bits follow the group being swept
      ctrl_d[`SACS_D_STAT_LSB+1:`SACS_D_STAT_LSB] <= cur_group;
    end
  end

  // Divider, conversion counter and sequencing state machine
  // The divider restarts with each conversion, so that the first
  // conversion clock is always a full one
  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state <= ST_IDLE;
      div_cnt <= 3'h0;
      conv_cnt <= 6'h00;
      idx <= 3'h0;
      second_group <= 1'b0;
      cur_group <= 2'h0;
    end
    else
    begin
      div_cnt <= phi_tick ? 3'h0 : div_cnt + 3'h1;
      if (state == ST_CONV && phi_tick)
        conv_cnt <= conv_cnt + 6'h01;
      case (state)
        ST_IDLE:
        begin
          // Idle keeps the sweep position parked at its start
          idx <= 3'h0;
          second_group <= 1'b0;
          cur_group <= grp_sel;
          conv_cnt <= 6'h00;
          if (start_bit)
          begin
            div_cnt <= 3'h0;
            state <= trg_sel ? ST_WAIT : ST_CONV;
          end
        end
        ST_WAIT, ST_CONV:
        begin
          // Clearing start wins over everything, a trigger too
          if (!start_bit)
            state <= ST_IDLE;
          else if (retrig)
          begin
            // A new trigger throws away the conversion in flight
            // so a late trigger never mixes two sampling windows
            state <= ST_CONV;
            div_cnt <= 3'h0;
            conv_cnt <= 6'h00;
            idx <= 3'h0;
            second_group <= 1'b0;
            cur_group <= grp_sel;
          end
          else if (conv_end)
          begin
            conv_cnt <= 6'h00;
            // Repeat modes run on; one-shot stops or waits again
            if (single_in)
            begin
              if (mode == `SACS_MODE_ONESHOT)
                state <= trg_sel ? ST_WAIT : ST_IDLE;
            end
            else if (!sweep_last)
              idx <= idx + 3'h1;
            else if (mps_en && !second_group)
            begin
              // Multi-port sweep moves on to the paired group
              idx <= 3'h0;
              second_group <= 1'b1;
              cur_group <= ctrl_e;
            end
            else
            begin
              idx <= 3'h0;
              second_group <= 1'b0;
              cur_group <= grp_sel;
              // Job done: stop, or wait for the next trigger
              if (stop_after)
                state <= trg_sel ? ST_WAIT : ST_IDLE;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Result store; dma mode funnels everything into entry zero
  // Eight-bit results are right aligned, the upper byte reads zero;
  // entries keep their value until their input is converted again
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_res
      always @(posedge mclk or posedge sys_rst)
      begin
        if (sys_rst)
          res[gi] <= 10'h000;
        else if (conv_end && ((dma_mode ? 3'h0 : cur_in) == gi))
          res[gi] <= res10 ? ana_data : {2'h0, ana_data[9:2]};
      end
    end
  endgenerate

  // Interrupt request: per conversion in dma mode, else at job end
  // A trigger in the last conversion clock gives no request, though the result is still stored;
  // repeat mode without dma gives no request at all
  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      adc_irq <= 1'b0;
    else if (conv_end && !retrig)
      adc_irq <= dma_mode || (mode == `SACS_MODE_ONESHOT) ||
                 (mode == `SACS_MODE_SWEEP && sweep_last &&
                  !(mps_en && !second_group));
    else
      adc_irq <= 1'b0;
  end

  // Analog side controls, all registered
  // Registered so the analog side never sees a decode glitch
  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ana_group <= 2'h0;
      ana_chan <= 3'h0;
      ana_ext <= 2'h0;
      ana_sample <= 1'b0;
      ana_convert <= 1'b0;
      ana_res10 <= 1'b0;
      ref_connect <= 1'b0;
    end
    else
    begin
      ana_group <= cur_group;
      ana_chan <= cur_in;
      // Single extra inputs only make sense outside the sweep modes
      ana_ext <= (!single_in && ctrl_b[`SACS_B_EXT_LSB] !=
                  ctrl_b[`SACS_B_EXT_LSB+1]) ? 2'h0 :
                 ctrl_b[`SACS_B_EXT_LSB+1:`SACS_B_EXT_LSB];
      // Sampling window lags the state by one clock, as the counter does
      ana_sample <= (state == ST_CONV) && (conv_cnt < samp_len);
      ana_convert <= (state == ST_CONV);
      ana_res10 <= res10;
      ref_connect <= ctrl_b[`SACS_B_REF];
    end
  end

  // Read port: data stand only in the cycle after the strobe
  // Unmapped addresses and idle cycles return zero; result bytes sit
  // at an even address for the low byte, odd for bits 9:8
  wire [11:0] res_off = reg_addr - `SACS_ADDR_RES_BASE;
  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      reg_rdata <= 8'h00;
    else if (!reg_rd)
      reg_rdata <= 8'h00;
    else if (reg_addr == `SACS_ADDR_CTRL_A)
      reg_rdata <= ctrl_a;
    else if (reg_addr == `SACS_ADDR_CTRL_B)
      reg_rdata <= ctrl_b;
    else if (reg_addr == `SACS_ADDR_CTRL_C)
      reg_rdata <= ctrl_c;
    else if (reg_addr == `SACS_ADDR_CTRL_D)
      reg_rdata <= ctrl_d;
    else if (reg_addr == `SACS_ADDR_CTRL_E)
      reg_rdata <= {6'h00, ctrl_e};
    else if (res_off < 12'h010)
      reg_rdata <= res_off[0] ? {6'h00, res[res_off[3:1]][9:8]} :
                   res[res_off[3:1]][7:0];
    else
      reg_rdata <= 8'h00;
  end
endmodule // sacs_adc_ctrl

// ==== verif/sacs_analog_model.sv ====
// Analog input source standing at the converter's far side
`timescale 1ns/10ps
module sacs_analog_model (
  input wire logic [1:0] ana_group,
  input wire logic [2:0] ana_chan,
  input wire logic [1:0] ana_ext,
  input wire logic ana_convert,
  output logic [9:0] ana_data
);
  logic [9:0] level;
  // Each input holds a level that encodes its own route
  assign level = {ana_group, ana_ext, ana_chan, 3'h5};
  // Outside a conversion the core output is junk, never a stale value
  assign ana_data = ana_convert ? level : ~level;
endmodule // sacs_analog_model

// ==== verif/sacs_adc_ctrl_assertions.sv ====
// Port checker of the converter control sequencer
`timescale 1ns/10ps
`include "sacs_defines.vh"
module sacs_adc_ctrl_checker (
  input wire mclk,
  input wire sys_rst,
  input wire [11:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire [1:0] ana_ext,
  input wire ana_sample,
  input wire ana_convert,
  input wire ana_res10,
  input wire ref_connect,
  input wire adc_irq
);
  logic ref_q, res_q, dma_q, start_q;
  logic [1:0] mode_q;
  logic [9:0] cnt;
  wire b_wr = reg_wr && reg_addr == `SACS_ADDR_CTRL_B;
  // Shadow of what software last wrote
  always @(posedge mclk or posedge sys_rst)
    if (sys_rst)
    begin
      {ref_q, res_q, dma_q, start_q, mode_q} <= 6'h00;
    end
    else if (reg_wr)
    begin
      if (b_wr)
        {ref_q, res_q} <= {reg_wdata[5], reg_wdata[3]};
      if (reg_addr == `SACS_ADDR_CTRL_D)
        dma_q <= reg_wdata[0];
      if (reg_addr == `SACS_ADDR_CTRL_A)
        {start_q, mode_q} <= {reg_wdata[6], reg_wdata[4:3]};
    end
  // Length of the running conversion in clocks
  always @(posedge mclk or posedge sys_rst)
    if (sys_rst)
      cnt <= 10'h000;
    else
      cnt <= ana_convert ? cnt + 10'h001 : 10'h000;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  ref_track_a: assert property (!b_wr && !$past(b_wr) |->
    ref_connect == ref_q) else $error("reference not as written");
  res_track_a: assert property (!b_wr && !$past(b_wr) |->
    ana_res10 == res_q) else $error("resolution not as written");
  irq_pulse_a: assert property (adc_irq |=> !adc_irq)
    else $error("interrupt longer than one cycle");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
  sample_conv_a: assert property (ana_sample |-> ana_convert)
    else $error("sampling outside conversion");
  irq_end_a: assert property ($rose(adc_irq) |->
    $past(ana_convert) && $past(cnt) >= 10'h014)
    else $error("interrupt without full conversion");
  start_conv_a: assert property ($rose(ana_convert) |-> start_q)
    else $error("conversion without start bit");
  irq_mode_a: assert property (adc_irq |->
    dma_q || mode_q != `SACS_MODE_REPEAT)
    else $error("interrupt in plain repeat mode");
  ext_force_a: assert property (ana_convert && mode_q[1] &&
    $past(mode_q[1]) |-> ana_ext != 2'h1 && ana_ext != 2'h2)
    else $error("extended input used in sweep");
  cover property ($rose(adc_irq) && dma_q);
  cover property ($rose(ana_convert) && mode_q == `SACS_MODE_SWEEP);
  cover property ($rose(adc_irq) && ana_res10);
endmodule // sacs_adc_ctrl_checker
bind sacs_adc_ctrl sacs_adc_ctrl_checker i_chk (.mclk, .sys_rst,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ana_ext,
  .ana_sample, .ana_convert, .ana_res10, .ref_connect, .adc_irq);

// ==== verif/test_sacs_adc_ctrl.sv ====
// Testbench of the converter control sequencer
`timescale 1ns/10ps
`include "sacs_defines.vh"
module test_sacs_adc_ctrl;
  logic mclk, sys_rst, reg_wr, reg_rd, ext_trigger_pin, timer_irq;
  logic [11:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [9:0] ana_data;
  logic [1:0] ana_group, ana_ext;
  logic [2:0] ana_chan;
  logic ana_sample, ana_convert, ana_res10, ref_connect, adc_irq;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  int n, k;
  sacs_adc_ctrl i_dut (.mclk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .ext_trigger_pin, .timer_irq, .ana_data,
    .ana_group, .ana_chan, .ana_ext, .ana_sample, .ana_convert,
    .ana_res10, .ref_connect, .adc_irq);
  sacs_analog_model i_src (.ana_group, .ana_chan, .ana_ext, .ana_convert,
    .ana_data);
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge mclk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic chk_rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge mclk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk({8'h00, reg_rdata}, {8'h00, e});
  endtask
  // Counts clocks up to the interrupt; the bound cuts a lost one short
  task automatic wait_irq(input int lo);
    n = 0;
    #1;
    while (adc_irq !== 1'b1 && n < 2000)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk(16'(n >= lo - 1 && n <= lo + 10), 16'h1);
  endtask
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      complete_run();
    end
  end
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial
  begin
    byte bv[4] = '{8'h30, 8'h38, 8'h30, 8'h38};
    byte cv[4] = '{8'h04, 8'h04, 8'h05, 8'h05};
    int lv[4] = '{49, 59, 28, 33};
    int dv[6] = '{4, 3, 2, 1, 8, 6};
    {reg_wr, reg_rd, reg_addr, reg_wdata} = 22'h0;
    {ext_trigger_pin, timer_irq, sys_rst} = 3'b101;
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    foreach (lv[i]) chk_rd(12'h394 + 12'(i), 8'h00);
    chk_rd(12'h3a0, 8'h00);
    wr(`SACS_ADDR_CTRL_C, 8'hff);
    chk_rd(`SACS_ADDR_CTRL_C, 8'he7);
    $display("register test done");
    wr(`SACS_ADDR_CTRL_B, 8'h38);
    @(posedge mclk);
    #1;
    chk({14'h0, ana_res10, ref_connect}, 16'h3);
    repeat (50) @(posedge mclk);
    for (int i = 0; i < 4; i++)
    begin
      wr(`SACS_ADDR_CTRL_B, bv[i]);
      wr(`SACS_ADDR_CTRL_C, cv[i]);
      wr(`SACS_ADDR_CTRL_A, 8'hc5);
      wait_irq(lv[i]);
      chk_rd(`SACS_ADDR_CTRL_A, 8'h85);
      chk_rd(12'h38a, bv[i][3] ? 8'h2d : 8'h8b);
      chk_rd(12'h38b, {6'h0, bv[i][3], 1'b0});
    end
    wr(`SACS_ADDR_CTRL_C, 8'h04);
    for (int i = 0; i < 6; i++)
    begin
      wr(`SACS_ADDR_CTRL_D, {5'h0, i[2], 2'h0});
      wr(`SACS_ADDR_CTRL_B, {3'h1, i[0], 4'h0});
      wr(`SACS_ADDR_CTRL_A, {i[1], 7'h45});
      wait_irq(49 * dv[i]);
    end
    $display("timing test done");
    wr(`SACS_ADDR_CTRL_D, 8'h01);
    wr(`SACS_ADDR_CTRL_A, 8'hc3);
    wait_irq(49);
    chk_rd(12'h380, 8'h87);
    chk_rd(12'h38a, 8'h8b);
    wr(`SACS_ADDR_CTRL_D, 8'h00);
    wr(`SACS_ADDR_CTRL_A, 8'hcd);
    k = 0;
    repeat (300) @(posedge mclk) k += adc_irq;
    chk({15'h0, ana_convert}, 16'h1);
    chk(16'(k), 16'h0);
    wr(`SACS_ADDR_CTRL_A, 8'h8d);
    repeat (3) @(posedge mclk);
    chk({15'h0, ana_convert}, 16'h0);
    wr(`SACS_ADDR_CTRL_B, 8'h70);
    wr(`SACS_ADDR_CTRL_A, 8'hd0);
    wait_irq(98);
    chk_rd(`SACS_ADDR_CTRL_A, 8'h90);
    chk_rd(12'h382, 8'h83);
    $display("mode test done");
    wr(`SACS_ADDR_CTRL_B, 8'h33);
    wr(`SACS_ADDR_CTRL_D, 8'h03);
    wr(`SACS_ADDR_CTRL_E, 8'h01);
    wr(`SACS_ADDR_CTRL_A, 8'hd0);
    k = 0;
    repeat (800) @(posedge mclk) k += adc_irq;
    chk(16'(k), 16'h10);
    chk_rd(12'h380, 8'h4f);
    chk_rd(`SACS_ADDR_CTRL_A, 8'h90);
    chk_rd(`SACS_ADDR_CTRL_D, 8'h13);
    wr(`SACS_ADDR_CTRL_D, 8'h00);
    wr(`SACS_ADDR_CTRL_E, 8'h00);
    $display("multi-port test done");
    wr(`SACS_ADDR_CTRL_A, 8'ha5);
    wr(`SACS_ADDR_CTRL_A, 8'he5);
    repeat (100) @(posedge mclk);
    chk({15'h0, ana_convert}, 16'h0);
    ext_trigger_pin <= 1'b0;
    wait_irq(49);
    @(posedge mclk);
    ext_trigger_pin <= 1'b1;
    chk_rd(`SACS_ADDR_CTRL_A, 8'he5);
    wr(`SACS_ADDR_CTRL_C, 8'h24);
    for (int i = 0; i < 2; i++)
    begin
      repeat (20) @(posedge mclk);
      timer_irq <= 1'b1;
      @(posedge mclk);
      timer_irq <= 1'b0;
    end
    wait_irq(49);
    $display("trigger test done");
    complete_run();
  end
endmodule // test_sacs_adc_ctrl
